/* rtl/lcdhp_pkg.sv */
package lcdhp_pkg;
    localparam int DATA_W = 16;
    localparam int INDEX_W = 8;
    localparam int SYNC_STAGES = 3;
    localparam logic [7:0] IDX_ACCESS_CTRL = 8'h05;
    localparam logic [7:0] IDX_MEM_DATA = 8'h0c;
    localparam logic [7:0] IDX_GOUT = 8'h06;
    localparam logic [7:0] IDX_GIN = 8'h07;
    localparam int BUS_WIDTH_BIT = 7;
    localparam logic [7:0] ACCESS_CTRL_RST = 8'h00;
    localparam logic [7:0] GOUT_RST = 8'h00;
    localparam logic [15:0] LANES_ALL = 16'hffff;
    localparam logic [15:0] LANES_LOW = 16'h00ff;
    localparam logic [15:0] LANES_SER = 16'h00c0;
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_PHASE_NS = 40;
    localparam int PHASE_CYC = (T_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_SCLK_HALF_NS = 60;
    localparam int SCLK_HALF_CYC =
        (T_SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] WB_CTRL = 8'h00;
    localparam logic [7:0] WB_WDATA = 8'h04;
    localparam logic [7:0] WB_CMD = 8'h08;
    localparam logic [7:0] WB_STATUS = 8'h0c;
    localparam logic [7:0] WB_RDATA = 8'h10;
    localparam int CTRL_PAR = 0;
    localparam int CTRL_STYLE = 1;
    localparam int CTRL_RUN = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam int CMD_IDS = 0;
    localparam int CMD_READ = 1;
    localparam int STATUS_BUSY = 0;
    localparam int STATUS_ERR = 1;
endpackage

/* rtl/lcdhp_if.sv */
`timescale 1ns/1ps
interface lcdhp_if;
    logic cs_n;
    logic rst_n;
    logic interface_type_select;
    logic bus_style_select;
    logic index_or_data_select;
    logic rd_e;
    logic wr_rw;
    logic [15:0] h_dout;
    logic [15:0] h_doe;
    logic [15:0] d_dout;
    logic [15:0] d_doe;
    logic [15:0] dbus;

    // Wire level per bit; an undriven line reads high
    assign dbus = (d_dout & d_doe) | (h_dout & h_doe) | ~(d_doe | h_doe);

    modport dev (
        input cs_n, rst_n, interface_type_select, bus_style_select,
        input index_or_data_select, rd_e, wr_rw, dbus,
        output d_dout, d_doe
    );
    modport host (
        output cs_n, rst_n, interface_type_select, bus_style_select,
        output index_or_data_select, rd_e, wr_rw, h_dout, h_doe,
        input dbus
    );
endinterface

/* rtl/lcdhp_dev_end.sv */
// What this block does
// - Strap high picks parallel, low picks serial
// - Parallel moves 8 or 16 bits per flag
// - Only act while chip select is low
// - Reset pin low holds logic in reset
// - Host pulses reset before any use
// - Strobe mode drives bus only during read
// - Strobe mode captures write on strobe rise
// - Direction low writes, high reads, enable qualifies
// - Enable validates each enable-mode access
// - Style strap picks strobes or enable-direction
// - Serial uses bit7 data, bit6 clock only
// - Deselected device releases all data pins
// - Select high data, low index byte
// - Serial samples select on eighth clock rise
// - Serial byte goes to index or data
// - Command reads four input port levels
// - Command sets eight output port levels
// - Index write loads index; index read forbidden
// - Serial mode has no read path
// - Width flag affects memory data writes and read lane count
`timescale 1ns/1ps
module lcdhp_dev_end #(
    parameter int GIN_W = 4,
    parameter int GOUT_W = 8
) (
    input wire logic i_core_clk, // System clock
    input wire logic i_sys_rst, // Synchronous reset, high
    lcdhp_if.dev bus, // Host port pins
    input wire logic [GIN_W-1:0] i_gin, // Input port pins
    output logic [GOUT_W-1:0] o_gout, // Output port pins
    output logic [lcdhp_pkg::DATA_W-1:0] o_mem_wdata, // Memory word
    output logic o_mem_wvalid, // Memory word strobe
    input wire logic [lcdhp_pkg::DATA_W-1:0] i_mem_rdata, // Memory read
    output logic [lcdhp_pkg::INDEX_W-1:0] o_cmd_index, // Command index
    output logic [7:0] o_cmd_data, // Command byte
    output logic o_cmd_valid, // Command strobe
    output logic o_serial_mode, // Serial path latched
    output logic o_in_reset // Internal reset active
);
    import lcdhp_pkg::*;

    localparam int SW = 7 + DATA_W + GIN_W;
    localparam int B_CS = SW - 1;
    localparam int B_RST = SW - 2;
    localparam int B_IDS = SW - 3;
    localparam int B_RDE = SW - 4;
    localparam int B_WRRW = SW - 5;
    localparam int B_PAR = SW - 6;
    localparam int B_STYLE = SW - 7;
    localparam logic [SW-1:0] F_RST = {2'b10, {(SW - 2){1'b0}}};

    function automatic logic rise(input logic cur, input logic prev);
        rise = cur & ~prev;
    endfunction

    logic [SW-1:0] s1_q, s2_q, s3_q, f_q, f_d, p_q;
    logic par_q, style_q;
    logic [7:0] index_q, acc_q, hi_q, shift_q;
    logic [GOUT_W-1:0] gout_q;
    logic pend_q;
    logic [2:0] cnt_q;
    logic [15:0] mem_wdata_q, dout_q, doe_q;
    logic mem_wvalid_q, cmd_valid_q;
    logic [7:0] cmd_index_q, cmd_data_q;

    wire [SW-1:0] raw = {bus.cs_n, bus.rst_n, bus.index_or_data_select,
        bus.rd_e, bus.wr_rw, bus.interface_type_select,
        bus.bus_style_select, bus.dbus, i_gin};
    // Level changes only once stages two and three agree
    assign f_d = (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));

    wire rst_int = i_sys_rst | ~f_q[B_RST];
    wire sel = ~f_q[B_CS];
    wire ids_f = f_q[B_IDS];
    wire [15:0] d_f = f_q[GIN_W +: DATA_W];
    wire [GIN_W-1:0] gin_f = f_q[GIN_W-1:0];
    wire sclk_f = f_q[GIN_W + 6];
    wire sclk_p = p_q[GIN_W + 6];
    wire si_f = f_q[GIN_W + 7];

    // Strobe style: write on write-strobe rise, read while read low
    wire strb_wr = rise(f_q[B_WRRW], p_q[B_WRRW]);
    wire strb_rd = ~f_q[B_RDE];
    // Enable style: enable qualifies, direction low writes
    wire en_wr = rise(p_q[B_RDE], f_q[B_RDE]) & ~f_q[B_WRRW];
    wire en_rd = f_q[B_RDE] & f_q[B_WRRW];
    wire par_wr = par_q & sel & (style_q ? en_wr : strb_wr);
    // Reads only in parallel mode with select high
    wire rd_act = par_q & sel & ids_f & (style_q ? en_rd : strb_rd);

    wire sclk_rise = ~par_q & sel & rise(sclk_f, sclk_p);
    wire ser_done = sclk_rise & (cnt_q == 3'h7);
    wire [7:0] ser_byte = {shift_q[6:0], si_f};

    wire wr_go = par_wr | ser_done;
    wire [15:0] wr_val = par_q ? d_f : {8'h00, ser_byte};
    wire [7:0] wr_byte = wr_val[7:0];
    wire mem16 = par_q & ~acc_q[BUS_WIDTH_BIT];
    wire wr_idx = wr_go & ~ids_f;
    wire wr_dat = wr_go & ids_f;
    wire wr_mem = wr_dat & (index_q == IDX_MEM_DATA);
    wire wr_acc = wr_dat & (index_q == IDX_ACCESS_CTRL);
    wire wr_gout = wr_dat & (index_q == IDX_GOUT);
    wire wr_cmd = wr_dat & ~wr_mem & ~wr_acc & ~wr_gout;
    // Byte-wide memory writes pair high byte first
    wire mem_out = wr_mem & (mem16 | pend_q);
    wire [15:0] mem_word = mem16 ? wr_val : {hi_q, wr_byte};

    wire [15:0] rd_val =
        (index_q == IDX_ACCESS_CTRL) ? {8'h00, acc_q} :
        (index_q == IDX_GIN) ? 16'(gin_f) :
        (index_q == IDX_GOUT) ? 16'(gout_q) :
        (index_q == IDX_MEM_DATA) ? i_mem_rdata : 16'h0000;
    wire [15:0] rd_lanes = mem16 ? LANES_ALL : LANES_LOW;

    always_ff @(posedge i_core_clk)
    begin
        s1_q <= raw;
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (i_sys_rst)
        begin
            f_q <= F_RST;
            p_q <= F_RST;
        end
        else
        begin
            f_q <= f_d;
            p_q <= f_q;
        end
    end

    // Straps are caught for as long as reset is held
    always_ff @(posedge i_core_clk)
    begin
        if (rst_int)
        begin
            par_q <= f_q[B_PAR];
            style_q <= f_q[B_STYLE];
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (rst_int | ~sel | par_q)
        begin
            cnt_q <= 3'h0;
            shift_q <= 8'h00;
        end
        else if (sclk_rise)
        begin
            cnt_q <= cnt_q + 3'h1;
            shift_q <= ser_byte;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (rst_int)
        begin
            index_q <= 8'h00;
            acc_q <= ACCESS_CTRL_RST;
            gout_q <= GOUT_W'(GOUT_RST);
            pend_q <= 1'b0;
            hi_q <= 8'h00;
        end
        else
        begin
            if (wr_idx)
                index_q <= wr_byte;
            if (wr_acc)
                acc_q <= wr_byte;
            if (wr_gout)
                gout_q <= wr_byte[GOUT_W-1:0];
            if (wr_idx | mem_out)
                pend_q <= 1'b0;
            else if (wr_mem)
                pend_q <= 1'b1;
            if (wr_mem & ~mem_out)
                hi_q <= wr_byte;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (rst_int)
        begin
            mem_wvalid_q <= 1'b0;
            cmd_valid_q <= 1'b0;
            mem_wdata_q <= 16'h0000;
            cmd_index_q <= 8'h00;
            cmd_data_q <= 8'h00;
            dout_q <= 16'h0000;
            doe_q <= 16'h0000;
        end
        else
        begin
            mem_wvalid_q <= mem_out;
            cmd_valid_q <= wr_cmd;
            if (mem_out)
                mem_wdata_q <= mem_word;
            if (wr_cmd)
            begin
                cmd_index_q <= index_q;
                cmd_data_q <= wr_byte;
            end
            dout_q <= rd_val;
            doe_q <= rd_act ? rd_lanes : 16'h0000;
        end
    end

    assign bus.d_dout = dout_q;
    assign bus.d_doe = doe_q;
    assign o_gout = gout_q;
    assign o_mem_wdata = mem_wdata_q;
    assign o_mem_wvalid = mem_wvalid_q;
    assign o_cmd_index = cmd_index_q;
    assign o_cmd_data = cmd_data_q;
    assign o_cmd_valid = cmd_valid_q;
    assign o_serial_mode = ~par_q;
    assign o_in_reset = rst_int;
endmodule

/* rtl/lcdhp_host_end.sv */
`timescale 1ns/1ps
module lcdhp_host_end (
    input wire logic i_core_clk, // System clock
    input wire logic i_sys_rst, // Synchronous reset, high
    input wire logic i_wb_cyc, // Wishbone cycle
    input wire logic i_wb_stb, // Wishbone strobe
    input wire logic i_wb_we, // Wishbone write
    input wire logic [7:0] i_wb_adr, // Wishbone byte address
    input wire logic [31:0] i_wb_dat, // Wishbone write data
    input wire logic [3:0] i_wb_sel, // Wishbone byte lanes
    output logic [31:0] o_wb_dat, // Wishbone read data
    output logic o_wb_ack, // Wishbone acknowledge
    lcdhp_if.host bus // Device port pins
);
    import lcdhp_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_SETUP = 3'b001,
        H_STROBE = 3'b010,
        H_HOLD = 3'b011,
        H_SLOW = 3'b100,
        H_SHIGH = 3'b101
    } lcdhp_hstate_t;

    localparam logic [7:0] PHASE = 8'(PHASE_CYC);
    localparam logic [7:0] HALF = 8'(SCLK_HALF_CYC);

    lcdhp_hstate_t st_q, st_d;
    logic [2:0] ctrl_q;
    logic [15:0] wdata_q, rdata_q, s1_q, s2_q, s3_q;
    logic ids_q, read_q, err_q, ack_q;
    logic [7:0] tmr_q;
    logic [2:0] bit_q;
    logic [31:0] dat_q;

    wire par = ctrl_q[CTRL_PAR];
    wire style = ctrl_q[CTRL_STYLE];
    wire req = i_wb_cyc & i_wb_stb;
    wire wr_fire = req & i_wb_we & ack_q;
    wire busy = (st_q != H_IDLE);
    wire start = wr_fire & (i_wb_adr == WB_CMD) & i_wb_sel[0] & ~busy;
    wire refuse = start & ~par & i_wb_dat[CMD_READ];
    wire tdone = (tmr_q == 8'h00);
    wire [31:0] rd_mux =
        (i_wb_adr == WB_CTRL) ? 32'(ctrl_q) :
        (i_wb_adr == WB_WDATA) ? 32'(wdata_q) :
        (i_wb_adr == WB_STATUS) ? 32'({err_q, busy}) :
        (i_wb_adr == WB_RDATA) ? 32'(rdata_q) : 32'h0000_0000;

    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            H_IDLE:
                if (start & ~refuse)
                    st_d = par ? H_SETUP : H_SLOW;
            H_SETUP:
                if (tdone)
                    st_d = H_STROBE;
            H_STROBE:
                if (tdone)
                    st_d = H_HOLD;
            H_HOLD:
                if (tdone)
                    st_d = H_IDLE;
            H_SLOW:
                if (tdone)
                    st_d = H_SHIGH;
            H_SHIGH:
                if (tdone)
                    st_d = (bit_q == 3'h0) ? H_HOLD : H_SLOW;
            default:
                st_d = H_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            st_q <= H_IDLE;
            tmr_q <= 8'h00;
            bit_q <= 3'h7;
        end
        else
        begin
            st_q <= st_d;
            if (st_d != st_q)
                tmr_q <= (st_d == H_SLOW || st_d == H_SHIGH) ? HALF : PHASE;
            else if (!tdone)
                tmr_q <= tmr_q - 8'h01;
            if (st_q == H_IDLE)
                bit_q <= 3'h7;
            else if (st_q == H_SHIGH && tdone)
                bit_q <= bit_q - 3'h1;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        s1_q <= bus.dbus;
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (i_sys_rst)
        begin
            ctrl_q <= CTRL_RST;
            wdata_q <= 16'h0000;
            rdata_q <= 16'h0000;
            ids_q <= 1'b0;
            read_q <= 1'b0;
            err_q <= 1'b0;
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= req & ~ack_q;
            if (req & ~ack_q)
                dat_q <= rd_mux;
            if (wr_fire & (i_wb_adr == WB_CTRL) & i_wb_sel[0] & ~busy)
                ctrl_q <= i_wb_dat[2:0];
            if (wr_fire & (i_wb_adr == WB_WDATA) & i_wb_sel[0])
                wdata_q[7:0] <= i_wb_dat[7:0];
            if (wr_fire & (i_wb_adr == WB_WDATA) & i_wb_sel[1])
                wdata_q[15:8] <= i_wb_dat[15:8];
            if (start)
            begin
                ids_q <= i_wb_dat[CMD_IDS];
                read_q <= i_wb_dat[CMD_READ];
                err_q <= refuse;
            end
            if (st_q == H_STROBE && tdone && read_q && s2_q == s3_q)
                rdata_q <= s3_q;
        end
    end

    wire strobe = (st_q == H_STROBE);
    wire par_drv = par & ~read_q & (st_q != H_IDLE);
    wire ser_drv = ~par & (st_q != H_IDLE);
    wire sclk = (st_q == H_SHIGH) | ((st_q == H_HOLD) & ~par);

    assign bus.rst_n = ctrl_q[CTRL_RUN];
    assign bus.interface_type_select = par;
    assign bus.bus_style_select = style;
    assign bus.cs_n = ~busy;
    assign bus.index_or_data_select = ids_q;
    assign bus.rd_e = style ? strobe : ~(strobe & read_q);
    assign bus.wr_rw = style ? (read_q | ~busy) :
        ~(strobe & ~read_q);
    assign bus.h_dout = par ? wdata_q :
        {8'h00, wdata_q[bit_q], sclk, 6'h00};
    assign bus.h_doe = par_drv ? LANES_ALL : (ser_drv ? LANES_SER : 16'h0000);
    assign o_wb_dat = dat_q;
    assign o_wb_ack = ack_q;
endmodule

/* test/lcdhp_sva.sv */
`timescale 1ns/1ps
module lcdhp_sva
    import lcdhp_pkg::*;
(
    input wire logic i_core_clk, // Clock
    input wire logic i_sys_rst, // Reset
    input wire logic cs_n, // Select
    input wire logic rst_n, // Device reset
    input wire logic par, // Parallel strap
    input wire logic style, // Style strap
    input wire logic ids, // Index or data
    input wire logic rd_e, // Read or enable
    input wire logic wr_rw, // Write or direction
    input wire logic [15:0] h_doe, // Host enables
    input wire logic [15:0] d_doe, // Device enables
    input wire logic [15:0] dbus // Wire
);
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);

    a_rst_start: assert property (disable iff (1'b0)
        i_sys_rst |=> !rst_n && cs_n) else $error("reset pin not held");
    a_held_quiet: assert property (!rst_n |-> d_doe == 16'h0)
        else $error("drive while held in reset");
    a_rel_desel: assert property (cs_n [*6] |-> d_doe == 16'h0)
        else $error("drive while deselected");
    a_serial_mute: assert property (!par |-> d_doe == 16'h0)
        else $error("drive in serial mode");
    a_host_lanes: assert property
        (!par |-> (h_doe & ~LANES_SER) == 16'h0)
        else $error("serial uses extra lanes");
    a_index_noread: assert property
        ((!ids && !cs_n) [*2] |-> d_doe == 16'h0)
        else $error("drive on index access");
    a_strobe_rel: assert property
        ((par && !style && rd_e) [*8] |-> d_doe == 16'h0)
        else $error("drive without read strobe");
    a_enable_rel: assert property
        ((par && style && !(rd_e && wr_rw)) [*8] |-> d_doe == 16'h0)
        else $error("drive without enabled read");
    a_strobe_idle: assert property
        (par && !style && cs_n |-> rd_e && wr_rw)
        else $error("strobe active outside select");
    a_enable_idle: assert property (par && style && cs_n |-> !rd_e)
        else $error("enable active outside select");
    a_sclk_still: assert property
        (!par && cs_n && $past(cs_n) |-> $stable(dbus[6]))
        else $error("serial clock moves outside frame");
endmodule

/* test/tb_lcd_driver_host_cpu_port.sv */
`timescale 1ns/1ps
module tb_lcd_driver_host_cpu_port;
    import lcdhp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic [3:0] gin = 4'h0;
    logic [15:0] mrd = 16'h0;
    logic [7:0] gout, cix, cdat;
    logic [15:0] mwd;
    logic mwv, cv, ser, inr;
    logic [16:0] exp_q[$];
    int error_cnt = 0;
    int total_checks = 0;

    always #2.5 clk = ~clk;

    lcdhp_if i_lcdhp_if();
    lcdhp_host_end i_lcdhp_host_end(.i_core_clk(clk), .i_sys_rst(rst),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(rdat), .o_wb_ack(ack),
        .bus(i_lcdhp_if));
    lcdhp_dev_end i_lcdhp_dev_end(.i_core_clk(clk), .i_sys_rst(rst),
        .bus(i_lcdhp_if), .i_gin(gin), .o_gout(gout), .o_mem_wdata(mwd),
        .o_mem_wvalid(mwv), .i_mem_rdata(mrd), .o_cmd_index(cix),
        .o_cmd_data(cdat), .o_cmd_valid(cv), .o_serial_mode(ser),
        .o_in_reset(inr));
    lcdhp_sva i_lcdhp_sva(.i_core_clk(clk), .i_sys_rst(rst),
        .cs_n(i_lcdhp_if.cs_n), .rst_n(i_lcdhp_if.rst_n),
        .par(i_lcdhp_if.interface_type_select),
        .style(i_lcdhp_if.bus_style_select),
        .ids(i_lcdhp_if.index_or_data_select),
        .rd_e(i_lcdhp_if.rd_e), .wr_rw(i_lcdhp_if.wr_rw),
        .h_doe(i_lcdhp_if.h_doe), .d_doe(i_lcdhp_if.d_doe),
        .dbus(i_lcdhp_if.dbus));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (error_cnt == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic hung();
        error_cnt++;
        $display("ERROR %0t: wait ran out", $time);
        report_and_stop();
    endtask

    // Classic single cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 100);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 100)
            hung();
        @(posedge clk);
    endtask

    // One link access, then wait for the port to go idle
    task automatic acc(input logic r_s, input logic rd, input logic [15:0] d,
                       output logic [15:0] v);
        logic [31:0] r;
        int n;
        n = 0;
        wb(1'b1, WB_WDATA, {16'h0, d}, r);
        wb(1'b1, WB_CMD, {30'h0, rd, r_s}, r);
        do
        begin
            wb(1'b0, WB_STATUS, 32'h0, r);
            n++;
        end
        while (r[STATUS_BUSY] !== 1'b0 && n < 200);
        if (n >= 200)
            hung();
        wb(1'b0, WB_RDATA, 32'h0, r);
        v = r[15:0];
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        logic [15:0] q;
        acc(1'b0, 1'b0, {8'h00, idx}, q);
        acc(1'b1, 1'b0, d, q);
    endtask

    task automatic rdi(input logic [7:0] idx, output logic [15:0] v);
        acc(1'b0, 1'b0, {8'h00, idx}, v);
        acc(1'b1, 1'b1, 16'h0, v);
    endtask

    // Memory word as two bytes, high byte first
    task automatic mem8(input logic [15:0] w);
        logic [15:0] q;
        exp_q.push_back({1'b0, w});
        acc(1'b0, 1'b0, {8'h00, IDX_MEM_DATA}, q);
        acc(1'b1, 1'b0, {8'h00, w[15:8]}, q);
        acc(1'b1, 1'b0, {8'h00, w[7:0]}, q);
    endtask

    // Straps change only while the device is held in reset
    task automatic mode(input logic p, input logic c);
        logic [31:0] r;
        wb(1'b1, WB_CTRL, {29'h0, 1'b0, c, p}, r);
        repeat (10) @(posedge clk);
        chk({31'h0, inr}, 32'h1);
        chk({24'h0, gout}, {24'h0, GOUT_RST});
        wb(1'b1, WB_CTRL, {29'h0, 1'b1, c, p}, r);
        repeat (20) @(posedge clk);
        chk({30'h0, inr, ser}, {30'h0, 1'b0, ~p});
    endtask

    always @(posedge clk)
    begin
        if (mwv === 1'b1 || cv === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(32'h1, 32'h0);
            else
                chk({15'h0, cv, cv ? {cix, cdat} : mwd},
                    {15'h0, exp_q.pop_front()});
        end
    end

    initial
    begin
        logic [31:0] r;
        logic [15:0] v, w;
        logic [7:0] b;
        void'($urandom(4));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, WB_CTRL, 32'h0, r);
        chk(r, {29'h0, CTRL_RST});
        wb(1'b0, 8'hfc, 32'h0, r);
        chk(r, 32'h0);
        for (int s = 0; s < 2; s++)
        begin
            mode(1'b1, s[0]);
            gin <= 4'($urandom);
            mrd <= 16'($urandom);
            b = 8'($urandom);
            w = 16'($urandom);
            wr(IDX_GOUT, {8'h00, b});
            chk({24'h0, gout}, {24'h0, b});
            rdi(IDX_GIN, v);
            chk({28'h0, v[3:0]}, {28'h0, gin});
            rdi(IDX_MEM_DATA, v);
            chk({16'h0, v}, {16'h0, mrd});
            exp_q.push_back({1'b0, w});
            wr(IDX_MEM_DATA, w);
            exp_q.push_back({1'b1, 8'h33, b});
            wr(8'h33, {~b, b});
            acc(1'b0, 1'b1, 16'h0, v);
            chk({16'h0, v}, 32'h0000ffff);
            wr(IDX_ACCESS_CTRL, 16'h0080);
            rdi(IDX_ACCESS_CTRL, v);
            chk({16'h0, v}, 32'h0000ff80);
            mem8(~w);
            wr(IDX_ACCESS_CTRL, 16'h0000);
        end
        mode(1'b0, 1'b0);
        w = 16'($urandom);
        b = 8'($urandom);
        mem8(w);
        exp_q.push_back({1'b1, 8'h33, ~b});
        wr(8'h33, {8'h00, ~b});
        wr(IDX_GOUT, {8'h00, b});
        chk({24'h0, gout}, {24'h0, b});
        acc(1'b1, 1'b1, 16'h0, v);
        wb(1'b0, WB_STATUS, 32'h0, r);
        chk({31'h0, r[STATUS_ERR]}, 32'h1);
        mode(1'b1, 1'b0);
        repeat (20) @(posedge clk);
        chk({31'h0, exp_q.size() == 0}, 32'h1);
        report_and_stop();
    end
endmodule
